// >>> inc/seqcf_pkg.sv
// Package with the offsets, field positions, masks and reset values of the sequencer bank.
package seqcf_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam int SEQCF_NREG = 15;
  localparam logic [3:0] SEQCF_GENERAL_IDX = 4'h0;
  localparam logic [3:0] SEQCF_DELAY_IDX = 4'h1;
  localparam logic [3:0] SEQCF_INTEG_IDX = 4'h2;
  localparam logic [3:0] SEQCF_REGION_IDX = 4'h3;
  localparam logic [3:0] SEQCF_RSVD4_IDX = 4'h4;
  localparam logic [3:0] SEQCF_DARK_IDX = 4'h5;
  localparam logic [3:0] SEQCF_PAD_IDX = 4'h6;
  localparam logic [3:0] SEQCF_TICKDIV_IDX = 4'h7;
  localparam logic [3:0] SEQCF_PERIOD_IDX = 4'h8;
  localparam logic [3:0] SEQCF_EXP1_IDX = 4'h9;
  localparam logic [3:0] SEQCF_EXP2_IDX = 4'hA;
  localparam logic [3:0] SEQCF_EXP3_IDX = 4'hB;
  localparam logic [3:0] SEQCF_AGAIN_IDX = 4'hC;
  localparam logic [3:0] SEQCF_DGAIN_IDX = 4'hD;
  localparam logic [3:0] SEQCF_SYNC_IDX = 4'hE;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SEQCF_GENERAL_RST = 16'h0000;
  localparam logic [15:0] SEQCF_DELAY_RST = 16'h0000;
  localparam logic [15:0] SEQCF_INTEG_RST = 16'h0004;
  localparam logic [15:0] SEQCF_REGION_RST = 16'h0001;
  localparam logic [15:0] SEQCF_RSVD4_RST = 16'h0000;
  localparam logic [15:0] SEQCF_DARK_RST = 16'h0102;
  localparam logic [15:0] SEQCF_PAD_RST = 16'h0000;
  localparam logic [15:0] SEQCF_TICKDIV_RST = 16'h0001;
  localparam logic [15:0] SEQCF_PERIOD_RST = 16'h0000;
  localparam logic [15:0] SEQCF_EXP1_RST = 16'h0000;
  localparam logic [15:0] SEQCF_EXP2_RST = 16'h0000;
  localparam logic [15:0] SEQCF_EXP3_RST = 16'h0000;
  localparam logic [15:0] SEQCF_AGAIN_RST = 16'h01E2;
  localparam logic [15:0] SEQCF_DGAIN_RST = 16'h0080;
  localparam logic [15:0] SEQCF_SYNC_RST = 16'h033F;

  // ----------------------------------------------------------------
  // Writable bit masks; reserved bits hold their default of zero
  // ----------------------------------------------------------------
  localparam logic [15:0] SEQCF_GENERAL_MSK = 16'h3FF3;
  localparam logic [15:0] SEQCF_DELAY_MSK = 16'hFFFF;
  localparam logic [15:0] SEQCF_INTEG_MSK = 16'h0007;
  localparam logic [15:0] SEQCF_REGION_MSK = 16'h00FF;
  localparam logic [15:0] SEQCF_RSVD4_MSK = 16'h0000;
  localparam logic [15:0] SEQCF_DARK_MSK = 16'h01FF;
  localparam logic [15:0] SEQCF_PAD_MSK = 16'h0FFF;
  localparam logic [15:0] SEQCF_WORD_MSK = 16'hFFFF;
  localparam logic [15:0] SEQCF_AGAIN_MSK = 16'h21E3;
  localparam logic [15:0] SEQCF_DGAIN_MSK = 16'h0FFF;
  localparam logic [15:0] SEQCF_SYNC_MSK = 16'h073F;

  localparam logic [15:0] SEQCF_RESET [0:14] = '{SEQCF_GENERAL_RST, SEQCF_DELAY_RST,
    SEQCF_INTEG_RST, SEQCF_REGION_RST, SEQCF_RSVD4_RST, SEQCF_DARK_RST, SEQCF_PAD_RST,
    SEQCF_TICKDIV_RST, SEQCF_PERIOD_RST, SEQCF_EXP1_RST, SEQCF_EXP2_RST, SEQCF_EXP3_RST,
    SEQCF_AGAIN_RST, SEQCF_DGAIN_RST, SEQCF_SYNC_RST};
  localparam logic [15:0] SEQCF_MASK [0:14] = '{SEQCF_GENERAL_MSK, SEQCF_DELAY_MSK,
    SEQCF_INTEG_MSK, SEQCF_REGION_MSK, SEQCF_RSVD4_MSK, SEQCF_DARK_MSK, SEQCF_PAD_MSK,
    SEQCF_WORD_MSK, SEQCF_WORD_MSK, SEQCF_WORD_MSK, SEQCF_WORD_MSK, SEQCF_WORD_MSK,
    SEQCF_AGAIN_MSK, SEQCF_DGAIN_MSK, SEQCF_SYNC_MSK};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEQCF_GEN_ENABLE_BIT = 0;
  localparam int SEQCF_GEN_ROLLING_BIT = 1;
  localparam int SEQCF_GEN_TRIG_BIT = 4;
  localparam int SEQCF_GEN_SLAVE_BIT = 5;
  localparam int SEQCF_GEN_DELAY_EN_BIT = 6;
  localparam int SEQCF_GEN_SUBSAMPLE_BIT = 7;
  localparam int SEQCF_GEN_BINNING_BIT = 8;
  localparam int SEQCF_GEN_STATS_WIN_BIT = 10;
  localparam int SEQCF_GEN_MON_LSB = 11;
  localparam int SEQCF_INT_KNEE2_BIT = 0;
  localparam int SEQCF_INT_KNEE3_BIT = 1;
  localparam int SEQCF_INT_PERIOD_SEL_BIT = 2;
  localparam int SEQCF_DARK_BLANK_BIT = 8;
  localparam int SEQCF_AGAIN_LAT_BIT = 13;
  localparam int SEQCF_AGAIN2_LSB = 5;

  // Sync groups: the number is the controlling bit of the sync register.
  localparam logic [3:0] SEQCF_GRP_LINE = 4'h0;
  localparam logic [3:0] SEQCF_GRP_DARK = 4'h1;
  localparam logic [3:0] SEQCF_GRP_PAD = 4'h2;
  localparam logic [3:0] SEQCF_GRP_EXP = 4'h3;
  localparam logic [3:0] SEQCF_GRP_GAIN = 4'h4;
  localparam logic [3:0] SEQCF_GRP_REGION = 4'h5;
  localparam logic [3:0] SEQCF_GRP_NONE = 4'hF;

  function automatic logic [3:0] seqcf_group(input int idx);
    case (idx)
      1: return SEQCF_GRP_LINE;
      3: return SEQCF_GRP_REGION;
      5: return SEQCF_GRP_DARK;
      6: return SEQCF_GRP_PAD;
      2, 7, 8, 9, 10, 11: return SEQCF_GRP_EXP;
      12, 13: return SEQCF_GRP_GAIN;
      default: return SEQCF_GRP_NONE;
    endcase
  endfunction

endpackage

// >>> hdl/seqcf_tick_gen.sv
// Exposure tick divider: one enable pulse every divider system clock periods.
`timescale 1ns/10ps
module seqcf_tick_gen
  import seqcf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [15:0] divider,
  output logic tick
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A divider of zero behaves as one so that the tick never stops.
  logic [15:0] count;
  wire logic [15:0] limit = (divider == 16'h0000) ? 16'h0001 : divider;
  wire logic last = (count >= limit - 16'h0001);

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      count <= (!run || last) ? 16'h0000 : count + 16'h0001;
      tick <= run && last;
    end
  end

endmodule // seqcf_tick_gen

// >>> hdl/seqcf_regs.sv
// Sequencer configuration register bank with frame-synchronised shadow copies.
`timescale 1ns/10ps
module seqcf_regs
  import seqcf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [3:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  input wire logic frame_start,
  output logic seq_enable,
  output logic rolling_mode,
  output logic triggered_mode,
  output logic slave_mode,
  output logic subsample_en,
  output logic binning_en,
  output logic stats_window_only,
  output logic [2:0] monitor_sel,
  output logic [7:0] rolling_line_readout_len,
  output logic [7:0] readout_delay,
  output logic knee2_en,
  output logic knee3_en,
  output logic period_interpretation_sel,
  output logic [15:0] frame_or_reset_period,
  output logic [7:0] active_regions,
  output logic [7:0] dark_row_count,
  output logic blank_first_line,
  output logic [11:0] padding_rows,
  output logic exposure_tick,
  output logic exposure_in_lines,
  output logic [15:0] primary_exposure,
  output logic [15:0] second_knee_exposure,
  output logic [15:0] third_knee_exposure,
  output logic [1:0] analog_gain_first,
  output logic [3:0] analog_gain_second,
  output logic [11:0] digital_gain_value
);

  // ----------------------------------------------------------------
  // Software-visible registers
  // ----------------------------------------------------------------
  logic [15:0] cfg [0:14];
  logic [15:0] act [0:14];
  logic [15:0] gain_pend [12:13];
  wire logic addr_ok = (cfg_addr < 4'hF);
  wire logic [15:0] sync_bits = cfg[SEQCF_SYNC_IDX];
  wire logic gain_lat = cfg[SEQCF_AGAIN_IDX][SEQCF_AGAIN_LAT_BIT];

  for (genvar i = 0; i < SEQCF_NREG; i++)
  begin : g_reg
    localparam logic [3:0] GRP = seqcf_group(i);
    wire logic hit = cfg_wr && (cfg_addr == 4'(i));
    wire logic held = (GRP != SEQCF_GRP_NONE) && sync_bits[GRP];
    wire logic upd = held ? frame_start : 1'b1;
    wire logic [15:0] next_act;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        cfg[i] <= SEQCF_RESET[i];
      else if (hit)
        cfg[i] <= cfg_wdata & SEQCF_MASK[i];
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
      if (!rst_b)
        act[i] <= SEQCF_RESET[i];
      else if (upd)
        act[i] <= next_act;
    end

    if (GRP == SEQCF_GRP_GAIN)
    begin : g_pend
      // With the gain sync bit set, the pending copy lags one frame, so with latency compensation on a new gain lands a frame later.
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          gain_pend[i] <= SEQCF_RESET[i];
        else if (frame_start || !held)
          gain_pend[i] <= cfg[i];
      end

      // Gain words go through a pending stage when latency compensation is on.
      assign next_act = gain_lat ? gain_pend[i] : cfg[i];
    end
    else
    begin : g_direct
      assign next_act = cfg[i];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped index 15 reads zero rather than aliasing a register.
  wire logic [15:0] next_rdata = addr_ok ? cfg[cfg_addr] : 16'h0000;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cfg_rdata <= 16'h0000;
    else if (cfg_rd)
      cfg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Decoded settings
  // ----------------------------------------------------------------
  wire logic [15:0] gen = act[SEQCF_GENERAL_IDX];
  wire logic [15:0] integ = act[SEQCF_INTEG_IDX];
  wire logic [15:0] dark = act[SEQCF_DARK_IDX];
  wire logic [15:0] again = act[SEQCF_AGAIN_IDX];
  wire logic rolling = gen[SEQCF_GEN_ROLLING_BIT];
  wire logic global_on = !rolling;
  wire logic delay_on = gen[SEQCF_GEN_DELAY_EN_BIT];
  wire logic [7:0] dark_raw = dark[7:0];
  // A zero count would leave no reference row, so it is raised to one.
  wire logic [7:0] dark_clamp = (dark_raw == 8'h00) ? 8'h01 : dark_raw;
  wire logic tick_w;

  seqcf_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .run(global_on),
    .divider(act[SEQCF_TICKDIV_IDX]),
    .tick(tick_w)
  );

  assign exposure_tick = tick_w;

  wire logic next_seq_enable = gen[SEQCF_GEN_ENABLE_BIT];
  wire logic next_triggered = gen[SEQCF_GEN_TRIG_BIT] && global_on;
  wire logic next_slave = gen[SEQCF_GEN_SLAVE_BIT] && global_on;
  wire logic next_subsample = gen[SEQCF_GEN_SUBSAMPLE_BIT];
  wire logic next_binning = gen[SEQCF_GEN_BINNING_BIT];
  wire logic next_stats_win = gen[SEQCF_GEN_STATS_WIN_BIT];
  wire logic [2:0] next_monitor_sel = gen[SEQCF_GEN_MON_LSB +: 3];
  wire logic [7:0] next_line_len = rolling ? act[SEQCF_DELAY_IDX][7:0] : 8'h00;
  wire logic [7:0] next_delay = delay_on ? act[SEQCF_DELAY_IDX][15:8] : 8'h00;
  wire logic next_blank = dark[SEQCF_DARK_BLANK_BIT];
  wire logic next_knee2 = integ[SEQCF_INT_KNEE2_BIT] && global_on;
  wire logic next_knee3 = integ[SEQCF_INT_KNEE3_BIT] && global_on;
  wire logic next_period_sel = integ[SEQCF_INT_PERIOD_SEL_BIT];
  wire logic [15:0] next_period = global_on ? act[SEQCF_PERIOD_IDX] : 16'h0000;
  wire logic [7:0] next_regions = act[SEQCF_REGION_IDX][7:0];
  wire logic [11:0] next_pad = rolling ? act[SEQCF_PAD_IDX][11:0] : 12'h000;
  wire logic [15:0] next_exp2 = global_on ? act[SEQCF_EXP2_IDX] : 16'h0000;
  wire logic [15:0] next_exp3 = global_on ? act[SEQCF_EXP3_IDX] : 16'h0000;
  wire logic [1:0] next_gain_first = again[1:0];
  wire logic [3:0] next_gain_second = again[SEQCF_AGAIN2_LSB +: 4];
  wire logic [11:0] next_dgain = act[SEQCF_DGAIN_IDX][11:0];

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seq_enable <= 1'b0;
      rolling_mode <= 1'b0;
      triggered_mode <= 1'b0;
      slave_mode <= 1'b0;
    end
    else
    begin
      seq_enable <= next_seq_enable;
      rolling_mode <= rolling;
      triggered_mode <= next_triggered;
      slave_mode <= next_slave;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      subsample_en <= 1'b0;
      binning_en <= 1'b0;
      stats_window_only <= 1'b0;
      monitor_sel <= 3'h0;
    end
    else
    begin
      subsample_en <= next_subsample;
      binning_en <= next_binning;
      stats_window_only <= next_stats_win;
      monitor_sel <= next_monitor_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rolling_line_readout_len <= 8'h00;
      readout_delay <= 8'h00;
      dark_row_count <= SEQCF_DARK_RST[7:0];
      blank_first_line <= SEQCF_DARK_RST[SEQCF_DARK_BLANK_BIT];
    end
    else
    begin
      rolling_line_readout_len <= next_line_len;
      readout_delay <= next_delay;
      dark_row_count <= dark_clamp;
      blank_first_line <= next_blank;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      knee2_en <= 1'b0;
      knee3_en <= 1'b0;
      period_interpretation_sel <= SEQCF_INTEG_RST[SEQCF_INT_PERIOD_SEL_BIT];
      frame_or_reset_period <= 16'h0000;
    end
    else
    begin
      knee2_en <= next_knee2;
      knee3_en <= next_knee3;
      period_interpretation_sel <= next_period_sel;
      frame_or_reset_period <= next_period;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active_regions <= SEQCF_REGION_RST[7:0];
      padding_rows <= 12'h000;
      exposure_in_lines <= 1'b0;
      primary_exposure <= 16'h0000;
    end
    else
    begin
      active_regions <= next_regions;
      padding_rows <= next_pad;
      exposure_in_lines <= rolling;
      primary_exposure <= act[SEQCF_EXP1_IDX];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      second_knee_exposure <= 16'h0000;
      third_knee_exposure <= 16'h0000;
      analog_gain_first <= SEQCF_AGAIN_RST[1:0];
      analog_gain_second <= SEQCF_AGAIN_RST[SEQCF_AGAIN2_LSB +: 4];
      digital_gain_value <= SEQCF_DGAIN_RST[11:0];
    end
    else
    begin
      second_knee_exposure <= next_exp2;
      third_knee_exposure <= next_exp3;
      analog_gain_first <= next_gain_first;
      analog_gain_second <= next_gain_second;
      digital_gain_value <= next_dgain;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence gain_load_s;
    frame_start && sync_bits[SEQCF_GRP_GAIN] && gain_lat;
  endsequence

  sequence quiet_s(grp_on);
    grp_on && !frame_start;
  endsequence

  tick_global_a: assert property (exposure_tick |-> $past(global_on))
    else $error("exposure tick seen in rolling mode");
  knee_gate_a: assert property (rolling |=> !knee2_en && !knee3_en)
    else $error("knee enable active in rolling mode");
  pad_gate_a: assert property (global_on |=> padding_rows == 12'h000)
    else $error("padding rows applied in global mode");
  delay_gate_a: assert property (!delay_on |=> readout_delay == 8'h00)
    else $error("readout delay applied while disabled");
  dark_min_a: assert property (##1 dark_row_count != 8'h00)
    else $error("dark row count fell to zero");
  exp_hold_a: assert property (quiet_s(sync_bits[SEQCF_GRP_EXP])
    |=> $stable(act[SEQCF_EXP1_IDX]))
    else $error("held exposure changed outside frame start");
  pad_follow_a: assert property (cfg_wr && cfg_addr == SEQCF_PAD_IDX && !sync_bits[SEQCF_GRP_PAD]
    |=> ##1 act[SEQCF_PAD_IDX] == ($past(cfg_wdata, 2) & SEQCF_PAD_MSK))
    else $error("unsynchronised padding update not applied");
  gain_lag_a: assert property (gain_load_s
    |=> act[SEQCF_AGAIN_IDX] == $past(gain_pend[SEQCF_AGAIN_IDX]))
    else $error("postponed gain not taken from pending stage");
  rsvd_read_a: assert property (cfg_rd && cfg_addr == SEQCF_RSVD4_IDX |=> cfg_rdata == 16'h0000)
    else $error("reserved word read nonzero");
  line_gate_a: assert property (global_on |=> rolling_line_readout_len == 8'h00)
    else $error("line readout length applied in global mode");
  period_gate_a: assert property (rolling |=> frame_or_reset_period == 16'h0000)
    else $error("frame or reset period applied in rolling mode");
  knee_time_a: assert property (rolling
    |=> (second_knee_exposure | third_knee_exposure) == 16'h0000)
    else $error("knee exposure applied in rolling mode");
  delay_follow_a: assert property (delay_on
    |=> readout_delay == $past(act[SEQCF_DELAY_IDX][15:8]))
    else $error("enabled readout delay not applied");
  mon_follow_a: assert property (monitor_sel == $past(gen[SEQCF_GEN_MON_LSB +: 3]))
    else $error("monitor select does not follow the general word");
  stats_follow_a: assert property (stats_window_only
    == $past(gen[SEQCF_GEN_STATS_WIN_BIT]))
    else $error("statistics window flag does not follow the general word");
  period_sel_a: assert property (period_interpretation_sel
    == $past(integ[SEQCF_INT_PERIOD_SEL_BIT]))
    else $error("period interpretation does not follow the integration word");
  dark_blank_a: assert property (blank_first_line == $past(dark[SEQCF_DARK_BLANK_BIT]))
    else $error("first line blanking does not follow the dark row word");
  line_hold_a: assert property (quiet_s(sync_bits[SEQCF_GRP_LINE])
    |=> $stable(act[SEQCF_DELAY_IDX]))
    else $error("held line length changed outside frame start");
  dark_hold_a: assert property (quiet_s(sync_bits[SEQCF_GRP_DARK])
    |=> $stable(act[SEQCF_DARK_IDX]))
    else $error("held dark rows changed outside frame start");
  pad_hold_a: assert property (quiet_s(sync_bits[SEQCF_GRP_PAD])
    |=> $stable(act[SEQCF_PAD_IDX]))
    else $error("held padding rows changed outside frame start");
  gain_hold_a: assert property (quiet_s(sync_bits[SEQCF_GRP_GAIN])
    |=> $stable(act[SEQCF_DGAIN_IDX]))
    else $error("held digital gain changed outside frame start");

endmodule // seqcf_regs

// >>> testbench/tb.sv
// Self-checking bench for the sequencer configuration register bank.
`timescale 1ns/10ps
module tb
  import seqcf_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] cfg_addr = 4'h0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [15:0] cfg_wdata = 16'h0000;
  logic frame_start = 1'b0;
  logic [15:0] cfg_rdata, frame_or_reset_period, primary_exposure;
  logic [15:0] second_knee_exposure, third_knee_exposure;
  logic seq_enable, rolling_mode, triggered_mode, slave_mode, subsample_en, binning_en;
  logic stats_window_only, knee2_en, knee3_en, period_interpretation_sel;
  logic blank_first_line, exposure_tick, exposure_in_lines, rd_pend;
  logic [2:0] monitor_sel;
  logic [7:0] rolling_line_readout_len, readout_delay, active_regions, dark_row_count;
  logic [11:0] padding_rows, digital_gain_value;
  logic [1:0] analog_gain_first;
  logic [3:0] analog_gain_second;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h51C2;
  int error_cnt = 0;
  int comparisons = 0;
  int n;

  always #5 sys_clk = ~sys_clk;

  seqcf_regs i_dut (.sys_clk, .rst_b, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata,
    .frame_start, .seq_enable, .rolling_mode, .triggered_mode, .slave_mode, .subsample_en,
    .binning_en, .stats_window_only, .monitor_sel, .rolling_line_readout_len,
    .readout_delay, .knee2_en, .knee3_en, .period_interpretation_sel,
    .frame_or_reset_period, .active_regions, .dark_row_count, .blank_first_line,
    .padding_rows, .exposure_tick, .exposure_in_lines, .primary_exposure,
    .second_knee_exposure, .third_knee_exposure, .analog_gain_first, .analog_gain_second,
    .digital_gain_value);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask

  // The expected word is noted before the strobe so the watcher never finds the queue empty.
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge sys_clk);
    cfg_rd <= 1'b0;
  endtask

  // Four edges cover the extra pending stage of a latency-compensated gain update.
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic frame();
    @(posedge sys_clk);
    frame_start <= 1'b1;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    settle();
  endtask

  task automatic wait_tick();
    int k;
    k = 0;
    while (exposure_tick !== 1'b1 && k < 20)
    begin
      @(posedge sys_clk);
      #1;
      k++;
      n++;
    end
    if (exposure_tick !== 1'b1)
    begin
      error_cnt++;
      $display("[ERR] %0t no exposure tick", $time);
      complete_run();
    end
  endtask

  // ----------------------------------------------------------------
  // Read data watcher
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rd_pend === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(cfg_rdata, 16'hXXXX);
      else
        chk(cfg_rdata, exp_q.pop_front());
    end
    rd_pend <= cfg_rd & rst_b;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 16; i++)
      rd(i[3:0], (i < 15) ? SEQCF_RESET[i] : 16'h0000);
    settle();
    chk(16'(dark_row_count), 16'h0002);
    chk(16'(blank_first_line), 16'h0001);
    chk(16'(period_interpretation_sel), 16'h0001);
    chk({analog_gain_second, 10'h000, analog_gain_first}, 16'hF002);
    // Random words land in every register but the sync word; reserved bits must read back as zero.
    for (int i = 0; i < 16; i++)
    begin
      if (i != 14)
      begin
        seed = lfsr(seed);
        wr(i[3:0], seed[15:0]);
        rd(i[3:0], (i < 15) ? (seed[15:0] & SEQCF_MASK[i]) : 16'h0000);
      end
    end
    wr(4'h0, 16'h0042);
    wr(4'h1, 16'h7733);
    wr(4'h6, 16'h0005);
    wr(4'h5, 16'h0000);
    frame();
    chk(16'(rolling_line_readout_len), 16'h0033);
    chk(16'(readout_delay), 16'h0077);
    chk(16'(dark_row_count), 16'h0001);
    chk(16'(blank_first_line), 16'h0000);
    chk({14'h0000, rolling_mode, exposure_in_lines}, 16'h0003);
    wr(4'h6, 16'h0FFF);
    wr(4'h1, 16'h0011);
    settle();
    chk(16'(padding_rows), 16'h0005);
    chk(16'(rolling_line_readout_len), 16'h0033);
    frame();
    chk(16'(padding_rows), 16'h0FFF);
    chk(16'(rolling_line_readout_len), 16'h0011);
    wr(4'hE, 16'h033A);
    wr(4'h6, 16'h0ABC);
    wr(4'h0, 16'h0002);
    settle();
    chk(16'(padding_rows), 16'h0ABC);
    chk(16'(readout_delay), 16'h0000);
    wr(4'h0, 16'h0000);
    settle();
    chk({padding_rows, 4'h0}, 16'h0000);
    chk({rolling_line_readout_len, 7'h00, exposure_in_lines}, 16'h0000);
    wr(4'hC, 16'h0040);
    frame();
    chk({analog_gain_second, 10'h000, analog_gain_first}, 16'h2000);
    wr(4'hC, 16'h2061);
    frame();
    chk({analog_gain_second, 10'h000, analog_gain_first}, 16'h2000);
    frame();
    chk({analog_gain_second, 10'h000, analog_gain_first}, 16'h3001);
    wr(4'hE, 16'h0322);
    wr(4'hD, 16'h0ABC);
    wr(4'h2, 16'h0003);
    wr(4'hA, 16'h1234);
    wr(4'hB, 16'h5678);
    wr(4'h8, 16'hBEEF);
    wr(4'h9, 16'h00AA);
    settle();
    chk(16'(digital_gain_value), 16'h0ABC);
    chk({13'h0000, period_interpretation_sel, knee3_en, knee2_en}, 16'h0003);
    chk(second_knee_exposure, 16'h1234);
    chk(third_knee_exposure, 16'h5678);
    chk(frame_or_reset_period, 16'hBEEF);
    chk(primary_exposure, 16'h00AA);
    wr(4'h0, 16'h3C02);
    settle();
    chk({knee3_en, knee2_en, frame_or_reset_period[13:0]}, 16'h0000);
    chk(frame_or_reset_period, 16'h0000);
    chk(second_knee_exposure | third_knee_exposure, 16'h0000);
    chk({12'h000, stats_window_only, monitor_sel}, 16'h000F);
    wr(4'h0, 16'h01B1);
    wr(4'h3, 16'h00A5);
    frame();
    chk({active_regions, 3'h0, binning_en, subsample_en, slave_mode, triggered_mode, seq_enable},
      16'hA51F);
    wr(4'h0, 16'h01B3);
    settle();
    chk({active_regions, 3'h0, binning_en, subsample_en, slave_mode, triggered_mode, seq_enable},
      16'hA519);
    wr(4'h0, 16'h0000);
    wr(4'h7, 16'h0003);
    settle();
    wait_tick();
    @(posedge sys_clk);
    #1;
    n = 1;
    wait_tick();
    chk(16'(n), 16'h0003);
    settle();
    complete_run();
  end
endmodule // tb
